// *** logic/uvoc_pkg.sv ***
// Constants and types shared by the undervoltage / overcurrent fault register block
`default_nettype none

package uvoc_pkg;

  // ----------------------------------------------------------------
  // Command codes and the all-phase select value
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_UV_LIMIT    = 8'h44;
  localparam logic [7:0]  CMD_UV_ACTION   = 8'h45;
  localparam logic [7:0]  CMD_OC_LIMIT    = 8'h46;
  localparam logic [7:0]  PHASE_ALL       = 8'hFF;

  // ----------------------------------------------------------------
  // Reset values (nonvolatile defaults) and the fixed OC exponent
  // ----------------------------------------------------------------
  localparam logic [15:0] UV_LIMIT_RESET  = 16'h0000;
  localparam logic [3:0]  UV_STEP_RESET   = 4'h0;
  localparam logic [7:0]  UV_ACTION_RESET = 8'h80;
  localparam logic [10:0] OC_MAN_RESET    = 11'h0A0;
  localparam logic [4:0]  OC_STEP_RESET   = 5'h14;
  localparam logic [4:0]  OC_EXP          = 5'h1E;

  // ----------------------------------------------------------------
  // Field positions of the response byte
  // ----------------------------------------------------------------
  localparam int          ACT_HI          = 7;
  localparam int          ACT_LO          = 6;
  localparam int          RETRY_HI        = 5;
  localparam int          RETRY_LO        = 3;
  localparam int          DLY_HI          = 2;
  localparam int          DLY_LO          = 0;

  // ----------------------------------------------------------------
  // Encodings and hardware steps
  // ----------------------------------------------------------------
  localparam logic [1:0]  ACT_CONTINUE    = 2'h0;
  localparam logic [1:0]  ACT_DELAYED     = 2'h1;
  localparam logic [1:0]  ACT_IMMEDIATE   = 2'h2;
  localparam logic [1:0]  ACT_INVALID     = 2'h3;
  localparam logic [2:0]  RETRY_NONE      = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER   = 3'h7;
  localparam logic [2:0]  DLY_SHORT       = 3'h1;
  localparam logic [2:0]  DLY_MID         = 3'h3;
  localparam logic [2:0]  DLY_LONG        = 3'h7;
  localparam logic [9:0]  UV_BASE         = 10'h258;
  localparam logic [9:0]  UV_STEP         = 10'h019;
  localparam int          UV_STEPS        = 15;
  localparam logic [25:0] PERMILLE        = 26'h00003E8;
  localparam logic [10:0] OC_MAX_Q        = 11'h0F8;
  localparam logic [4:0]  OC_MIN_STEP     = 5'h04;
  localparam int          PHASES          = 4;

  typedef enum logic [2:0] {
    ST_OFF, ST_START, ST_RUN, ST_DELAY, ST_WAIT, ST_LATCH
  } uvoc_state_type;

endpackage : uvoc_pkg

`default_nettype wire

// *** logic/uvoc_fault_regs.sv ***
// Undervoltage fault limit / response and overcurrent fault limit command logic
//
// Operation
// RULE_01: UV threshold stored as percentage, format-aware conversion
// RULE_02: UV steps 60% to 95% by 2.5%
// RULE_03: Off-step UV value rounds down
// RULE_04: Invalid writes flag status and alert host
// RULE_05: UV fault sets byte, word, vout bits
// RULE_06: Host alerted after UV status set
// RULE_07: Action field: continue, delayed, immediate off
// RULE_08: Retry zero latches off
// RULE_09: Retry 1-6: restart_wait_period, bounded restarts, latch
// RULE_10: Retry 7: restart forever until off/success
// RULE_11: Delay 0-1: one PWM period, one rise
// RULE_12: Delay 2-4: three periods, code times rise
// RULE_13: Delay 5-7: seven periods, code times rise
// RULE_14: OC limit linear word, exponent 11110b
// RULE_15: OC at most 62 A per phase
// RULE_16: Stack limit is smallest setting times phases
// RULE_17: OC fault requests separate response action
// RULE_18: OC hardware 8-62 A, 2 A, round up
// RULE_19: OC below 8 A applied as 8 A
// RULE_20: Restore rounds to nearest quarter ampere
// RULE_21: All-phase write divides by phase count
// RULE_22: All-phase read is phase 0 times count
// RULE_23: Single-phase access touches that phase only
// RULE_24: Restart counter clears on success or off
`default_nettype none

module uvoc_fault_regs (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Command port from the management link engine
  input  wire logic             cmd_valid,
  input  wire logic             cmd_write,
  input  wire logic [7:0]       cmd_code,
  input  wire logic [15:0]      cmd_wdata,
  output logic                  rsp_valid,
  output logic      [15:0]      rsp_rdata,
  // Configuration from neighbouring command logic
  input  wire logic [7:0]       phase_select,
  input  wire logic [2:0]       phase_total,
  input  wire logic [15:0]      vout_command,
  input  wire logic             vout_relative,
  input  wire logic [15:0]      ton_rise_cycles,
  input  wire logic             operation_on,
  input  wire logic             nvm_restore,
  input  wire logic             status_clear,
  // Asynchronous pins
  input  wire logic             pwm_clk,
  input  wire logic             uv_trip,
  input  wire logic             startup_ok,
  input  wire logic             oc_trip,
  // Power stage control
  output logic                  regulator_enable,
  output logic      [3:0]       uv_step,
  output logic      [3:0][4:0]  oc_phase_step,
  output logic      [7:0]       stack_oc_step,
  output logic                  oc_response_request,
  // Status and alert
  output logic                  status_byte_other,
  output logic                  status_byte_cml,
  output logic                  status_word_vout,
  output logic                  status_undervoltage_fault_flag,
  output logic                  status_cml_data,
  output logic                  alert_out,
  output logic                  alert_oe
);
  import uvoc_pkg::*;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] uvoc_ones(input logic [14:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < UV_STEPS; i++) begin
      n = n + 4'(v[i]);
    end
    return n;
  endfunction : uvoc_ones

  function automatic logic [10:0] uvoc_div(input logic [23:0] v, input logic [2:0] n);
    case (n)
      3'h2:    return 11'(v / 24'h000002);
      3'h3:    return 11'(v / 24'h000003);
      3'h4:    return 11'(v / 24'h000004);
      default: return 11'(v);
    endcase
  endfunction : uvoc_div

  // Quarter amperes to 2 A hardware code, rounded up, floored at 8 A
  function automatic logic [4:0] uvoc_hw_step(input logic [10:0] q);
    logic [11:0] t;
    t = 12'(q) + 12'h007; // RULE_18
    return (t[7:3] < OC_MIN_STEP) ? OC_MIN_STEP : t[7:3]; // RULE_19
  endfunction : uvoc_hw_step

  function automatic logic [2:0] uvoc_shut_len(input logic [2:0] c);
    if (c < 3'h2) return DLY_SHORT; // RULE_11
    else if (c < 3'h5) return DLY_MID; // RULE_12
    else return DLY_LONG; // RULE_13
  endfunction : uvoc_shut_len

  function automatic logic [2:0] uvoc_restart_wait_period(input logic [2:0] c);
    return (c < 3'h2) ? 3'h1 : c; // RULE_11
  endfunction : uvoc_restart_wait_period

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync_meta;
  logic [3:0] sync_pin;
  logic       pwm_prev;
  logic       oc_prev;
  logic       pwm_edge;
  logic       uv_s;
  logic       start_s;
  logic       oc_s;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_meta <= 4'h0;
      sync_pin  <= 4'h0;
      pwm_prev  <= 1'b0;
      oc_prev   <= 1'b0;
    end else begin
      sync_meta <= {oc_trip, startup_ok, uv_trip, pwm_clk};
      sync_pin  <= sync_meta;
      pwm_prev  <= sync_pin[0];
      oc_prev   <= sync_pin[3];
    end
  end

  assign pwm_edge = sync_pin[0] & ~pwm_prev;
  assign uv_s     = sync_pin[1];
  assign start_s  = sync_pin[2];
  assign oc_s     = sync_pin[3];

  // ----------------------------------------------------------------
  // Write decode and value mapping
  // ----------------------------------------------------------------
  logic        wr;
  logic        all_ph;
  logic [1:0]  ph;
  logic [15:0] uv_limit;
  logic [7:0]  uv_action;
  logic [10:0] oc_man [PHASES];
  logic [25:0] uv_lhs;
  logic [25:0] uv_top;
  logic [14:0] uv_ge;
  logic        uv_ok;

  assign wr     = cmd_valid & cmd_write;
  assign all_ph = phase_select == PHASE_ALL;
  assign ph     = phase_select[1:0];
  // Relative format is taken as permille of the commanded output
  assign uv_lhs = vout_relative ? 26'(cmd_wdata) : 26'(cmd_wdata) * PERMILLE; // RULE_01

  for (genvar k = 0; k < UV_STEPS; k++) begin : g_uv
    localparam logic [25:0] PCT = 26'(UV_BASE) + 26'(k) * 26'(UV_STEP);
    logic [25:0] rhs;
    assign rhs      = vout_relative ? PCT : 26'(vout_command) * PCT; // RULE_02
    assign uv_ge[k] = uv_lhs >= rhs;
    if (k == UV_STEPS - 1) begin : g_top
      assign uv_top = rhs;
    end
  end

  assign uv_ok = uv_ge[0] & (uv_lhs <= uv_top); // RULE_04

  logic [5:0]  oc_shift;
  logic [4:0]  oc_nsh;
  logic [23:0] oc_man_w;
  logic [23:0] oc_q;
  logic [23:0] oc_half_w;
  logic        oc_rem;
  logic        oc_big;
  logic [10:0] oc_lim;
  logic [23:0] oc_ceil;
  logic [23:0] oc_near;
  logic        oc_ok;

  // Linear word converted to quarter amperes, keeping truncated, ceiling and nearest forms
  always_comb begin
    oc_shift  = {cmd_wdata[15], cmd_wdata[15:11]} + 6'h02;
    oc_nsh    = 5'(6'h00 - oc_shift);
    oc_man_w  = 24'(cmd_wdata[9:0]);
    oc_half_w = 24'h000000;
    oc_rem    = 1'b0;
    oc_big    = 1'b0;
    if (oc_shift[5]) begin
      oc_q      = oc_man_w >> oc_nsh;
      oc_rem    = (oc_q << oc_nsh) != oc_man_w;
      oc_half_w = oc_man_w >> (oc_nsh - 5'h01);
    end else begin
      oc_q   = oc_man_w << oc_shift[4:0];
      oc_big = (oc_shift[4:0] > 5'h09) & (|cmd_wdata[9:0]);
    end
    oc_lim  = all_ph ? 11'(OC_MAX_Q * 11'(phase_total)) : OC_MAX_Q; // RULE_15
    oc_ceil = oc_q + 24'(oc_rem);
    oc_near = oc_q + 24'(oc_half_w[0]); // RULE_20
    oc_ok   = ~cmd_wdata[10] & ~oc_big & (oc_ceil <= 24'(oc_lim));
  end

  // ----------------------------------------------------------------
  // Command registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      uv_limit  <= UV_LIMIT_RESET;
      uv_step   <= UV_STEP_RESET;
      uv_action <= UV_ACTION_RESET;
    end else begin
      if (wr && cmd_code == CMD_UV_LIMIT && uv_ok) begin
        uv_limit <= cmd_wdata;
        uv_step  <= uvoc_ones(uv_ge) - 4'h1; // RULE_03
      end
      if (wr && cmd_code == CMD_UV_ACTION && cmd_wdata[ACT_HI:ACT_LO] != ACT_INVALID) begin
        uv_action <= cmd_wdata[7:0]; // RULE_07
      end
    end
  end

  for (genvar i = 0; i < PHASES; i++) begin : g_ph
    always_ff @(posedge core_clk) begin
      if (rst) begin
        oc_man[i]        <= OC_MAN_RESET;
        oc_phase_step[i] <= OC_STEP_RESET;
      end else if (wr && cmd_code == CMD_OC_LIMIT && oc_ok && all_ph) begin
        oc_man[i]        <= uvoc_div(oc_near, phase_total); // RULE_21
        oc_phase_step[i] <= uvoc_hw_step(uvoc_div(oc_ceil, phase_total));
      end else if (wr && cmd_code == CMD_OC_LIMIT && oc_ok && ph == 2'(i)) begin
        oc_man[i]        <= 11'(oc_near); // RULE_23
        oc_phase_step[i] <= uvoc_hw_step(11'(oc_ceil)); // RULE_18
      end else if (nvm_restore) begin
        oc_phase_step[i] <= uvoc_hw_step(oc_man[i]); // RULE_20
      end
    end
    a_oc_floor: assert property (oc_phase_step[i] >= OC_MIN_STEP) // RULE_19
      else $error("phase current step below floor");
  end

  // ----------------------------------------------------------------
  // Read path and stack limit
  // ----------------------------------------------------------------
  logic [7:0] stack_min;

  always_comb begin
    stack_min = 8'(oc_phase_step[0]);
    for (int i = 1; i < PHASES; i++) begin
      if (3'(i) < phase_total && 8'(oc_phase_step[i]) < stack_min) begin
        stack_min = 8'(oc_phase_step[i]);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rsp_valid     <= 1'b0;
      rsp_rdata     <= 16'h0000;
      stack_oc_step <= 8'h00;
    end else begin
      rsp_valid     <= cmd_valid & ~cmd_write;
      stack_oc_step <= 8'(stack_min * 8'(phase_total)); // RULE_16
      case (cmd_code)
        CMD_UV_LIMIT:  rsp_rdata <= uv_limit;
        CMD_UV_ACTION: rsp_rdata <= {8'h00, uv_action};
        CMD_OC_LIMIT:  rsp_rdata <= {OC_EXP, all_ph ? 11'(oc_man[0] * 11'(phase_total)) // RULE_22
                                                   : oc_man[ph]}; // RULE_14
        default:       rsp_rdata <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status flags and alert
  // ----------------------------------------------------------------
  uvoc_state_type st;
  logic           uv_event;
  logic           inval;

  assign uv_event = (st == ST_RUN) & uv_s & operation_on;
  assign inval    = wr & ((cmd_code == CMD_UV_LIMIT && !uv_ok)
                    | (cmd_code == CMD_UV_ACTION && cmd_wdata[ACT_HI:ACT_LO] == ACT_INVALID)
                    | (cmd_code == CMD_OC_LIMIT && !oc_ok));

  // A new event beats a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_byte_other   <= 1'b0;
      status_word_vout    <= 1'b0;
      status_undervoltage_fault_flag     <= 1'b0;
      status_cml_data     <= 1'b0;
      status_byte_cml     <= 1'b0;
      alert_oe            <= 1'b0;
      alert_out           <= 1'b0;
      oc_response_request <= 1'b0;
    end else begin
      status_byte_other   <= uv_event | (status_byte_other & ~status_clear); // RULE_05
      status_word_vout    <= uv_event | (status_word_vout & ~status_clear);
      status_undervoltage_fault_flag     <= uv_event | (status_undervoltage_fault_flag & ~status_clear);
      status_cml_data     <= inval | (status_cml_data & ~status_clear); // RULE_04
      status_byte_cml     <= inval | (status_byte_cml & ~status_clear);
      alert_oe            <= status_undervoltage_fault_flag | status_cml_data; // RULE_06
      alert_out           <= 1'b0;
      oc_response_request <= oc_s & ~oc_prev; // RULE_17
    end
  end

  // ----------------------------------------------------------------
  // Undervoltage response sequencer
  // ----------------------------------------------------------------
  logic [15:0] cnt;
  logic [2:0]  mult;
  logic [2:0]  attempts;
  logic [2:0]  retry;
  logic [2:0]  dcode;
  logic        can_retry;

  assign retry     = uv_action[RETRY_HI:RETRY_LO];
  assign dcode     = uv_action[DLY_HI:DLY_LO];
  assign can_retry = (retry == RETRY_FOREVER) // RULE_10
                   | (retry != RETRY_NONE && attempts < retry); // RULE_08 RULE_09

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st               <= ST_OFF;
      cnt              <= 16'h0000;
      mult             <= 3'h0;
      attempts         <= 3'h0;
      regulator_enable <= 1'b0;
    end else if (!operation_on) begin
      st               <= ST_OFF;
      attempts         <= 3'h0; // RULE_24
      regulator_enable <= 1'b0;
    end else begin
      case (st)
        ST_OFF: begin
          st               <= ST_START;
          cnt              <= 16'h0000;
          regulator_enable <= 1'b1;
        end
        ST_START: begin
          if (start_s) begin
            st       <= ST_RUN;
            attempts <= 3'h0; // RULE_24
          end else if (cnt >= ton_rise_cycles) begin
            regulator_enable <= 1'b0;
            cnt              <= 16'h0000;
            mult             <= 3'h0;
            st               <= can_retry ? ST_WAIT : ST_LATCH; // RULE_09
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        ST_RUN: begin
          if (uv_s && uv_action[ACT_HI:ACT_LO] == ACT_DELAYED) begin
            st  <= ST_DELAY; // RULE_07
            cnt <= 16'h0000;
          end else if (uv_s && uv_action[ACT_HI:ACT_LO] == ACT_IMMEDIATE) begin
            regulator_enable <= 1'b0; // RULE_07
            cnt              <= 16'h0000;
            mult             <= 3'h0;
            st               <= can_retry ? ST_WAIT : ST_LATCH; // RULE_08
          end
        end
        ST_DELAY: begin
          if (pwm_edge && cnt[2:0] == uvoc_shut_len(dcode) - 3'h1) begin
            regulator_enable <= 1'b0;
            cnt              <= 16'h0000;
            mult             <= 3'h0;
            st               <= can_retry ? ST_WAIT : ST_LATCH;
          end else if (pwm_edge) begin
            cnt <= cnt + 16'h0001;
          end
        end
        ST_WAIT: begin
          if (cnt >= ton_rise_cycles && mult == uvoc_restart_wait_period(dcode) - 3'h1) begin
            st               <= ST_START; // RULE_12 RULE_13
            cnt              <= 16'h0000;
            regulator_enable <= 1'b1;
            attempts         <= (attempts == 3'h7) ? attempts : attempts + 3'h1;
          end else if (cnt >= ton_rise_cycles) begin
            cnt  <= 16'h0000;
            mult <= mult + 3'h1;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        ST_LATCH: regulator_enable <= 1'b0;
        default:  st <= ST_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_uv_hit(logic [1:0] a);
    st == ST_RUN && uv_s && operation_on && uv_action[ACT_HI:ACT_LO] == a;
  endsequence

  a_bad_write_flag: assert property (inval |=> status_cml_data ##1 alert_oe) // RULE_04
    else $error("invalid write not flagged");
  a_uv_status_set: assert property (uv_event |=> status_undervoltage_fault_flag && status_word_vout
                                     && status_byte_other) // RULE_05
    else $error("undervoltage status not set");
  a_alert_follow: assert property ($rose(status_undervoltage_fault_flag) |=> alert_oe) // RULE_06
    else $error("alert not raised");
  a_uv_continue: assert property (s_uv_hit(ACT_CONTINUE) |=> st == ST_RUN
                                   && regulator_enable) // RULE_07
    else $error("continue action stopped output");
  a_uv_latch_off: assert property (s_uv_hit(ACT_IMMEDIATE) ##0 retry == RETRY_NONE
                                    |=> st == ST_LATCH && !regulator_enable) // RULE_08
    else $error("no-retry fault did not latch");
  a_delay_length: assert property (st == ST_DELAY && pwm_edge && operation_on
                                    && cnt[2:0] < uvoc_shut_len(dcode) - 3'h1
                                    |=> st == ST_DELAY && regulator_enable) // RULE_11 RULE_12 RULE_13
    else $error("shutdown delay too short");
  a_restart_wait_period_restart: assert property (st == ST_WAIT && operation_on && cnt >= ton_rise_cycles
                                      && mult == uvoc_restart_wait_period(dcode) - 3'h1
                                      |=> st == ST_START && regulator_enable) // RULE_09
    else $error("restart after restart_wait_period missing");
  a_forever_retry: assert property (st == ST_START && operation_on && !start_s
                                     && cnt >= ton_rise_cycles && retry == RETRY_FOREVER
                                     |=> st == ST_WAIT) // RULE_10
    else $error("unlimited retry stopped");
  a_oc_all_read: assert property (cmd_valid && !cmd_write && cmd_code == CMD_OC_LIMIT
                                   && all_ph |=> rsp_valid && rsp_rdata[15:11] == OC_EXP
                                   && rsp_rdata[10:0] == 11'($past(oc_man[0])
                                   * 11'($past(phase_total)))) // RULE_22
    else $error("all-phase read wrong");
  a_oc_fault_pulse: assert property ($rose(oc_s) |=> oc_response_request) // RULE_17
    else $error("overcurrent response not requested");
  a_restart_clear: assert property (st == ST_START && start_s && operation_on
                                     |=> attempts == 3'h0 && st == ST_RUN) // RULE_24
    else $error("restart counter not cleared");

endmodule : uvoc_fault_regs

`default_nettype wire

// *** bench/uvoc_stage_model.sv ***
// Power stage model: free switching clock, start-up flag, undervoltage comparator
`default_nettype none
module uvoc_stage_model (
  // Control from the block and the bench
  input  wire logic regulator_enable,
  input  wire logic uv_force,
  // Pins toward the block
  output logic      pwm_clk,
  output logic      startup_ok,
  output logic      uv_trip
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pwm_clk = 1'b0;
    forever #40 pwm_clk = ~pwm_clk;
  end
  initial startup_ok = 1'b0;
  // Output settles some time after the stage is enabled
  always @(regulator_enable) startup_ok <= #100 regulator_enable;
  // An unregulated output reads as undervoltage, as the real comparator would
  assign uv_trip = uv_force | ~startup_ok;
endmodule : uvoc_stage_model
`default_nettype wire

// *** bench/uv_oc_fault_limit_response_regs_bench.sv ***
// Self-checking bench for the fault limit and response register block
`default_nettype none
module uv_oc_fault_limit_response_regs_bench;
  import uvoc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, cmd_valid, cmd_write, vout_relative, operation_on, nvm_restore;
  logic status_clear, pwm_clk, uv_trip, startup_ok, oc_trip, uv_force, seen;
  logic rsp_valid, regulator_enable, oc_req, alert_out, alert_oe;
  logic s_other, s_bcml, s_word, s_uvf, s_cml;
  logic [7:0] cmd_code, phase_select, stack_oc_step;
  logic [15:0] cmd_wdata, rsp_rdata, vout_command, ton_rise_cycles;
  logic [2:0] phase_total;
  logic [3:0] uv_step;
  logic [3:0][4:0] oc_phase_step;
  logic [31:0] seed = 32'h0000B6C2;
  int error_cnt, tests_run, v, i;
  // ----------------------------------------------------------------
  // Checking and expectation helpers
  // ----------------------------------------------------------------
  task automatic check(string name, logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  function automatic int rnd(int span);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed % span);
  endfunction : rnd
  // Quarter-amp mantissa to 2 A code: ceiling, floor at 8 A
  function automatic logic [15:0] oc_exp(int q);
    return (q < 32) ? 16'h0004 : 16'((q + 7) / 8);
  endfunction : oc_exp
  task automatic bus(logic wr, logic [7:0] code, logic [15:0] data);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code  <= code;
    cmd_wdata <= data;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask : bus
  task automatic report_and_stop;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  uvoc_fault_regs dut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .phase_select(phase_select),
    .phase_total(phase_total), .vout_command(vout_command), .vout_relative(vout_relative),
    .ton_rise_cycles(ton_rise_cycles), .operation_on(operation_on),
    .nvm_restore(nvm_restore), .status_clear(status_clear), .pwm_clk(pwm_clk),
    .uv_trip(uv_trip), .startup_ok(startup_ok), .oc_trip(oc_trip),
    .regulator_enable(regulator_enable), .uv_step(uv_step), .oc_phase_step(oc_phase_step),
    .stack_oc_step(stack_oc_step), .oc_response_request(oc_req),
    .status_byte_other(s_other), .status_byte_cml(s_bcml), .status_word_vout(s_word),
    .status_undervoltage_fault_flag(s_uvf), .status_cml_data(s_cml), .alert_out(alert_out),
    .alert_oe(alert_oe));
  uvoc_stage_model stage (.regulator_enable(regulator_enable), .uv_force(uv_force),
    .pwm_clk(pwm_clk), .startup_ok(startup_ok), .uv_trip(uv_trip));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #100us;
    error_cnt++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b1, 26'h0};
    {nvm_restore, status_clear, oc_trip, uv_force, operation_on} = 5'h00;
    phase_select = 8'h00;
    phase_total = 3'h4;
    vout_command = 16'h03E8;
    vout_relative = 1'b1;
    ton_rise_cycles = 16'h0014;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, CMD_UV_ACTION, 16'h0000);
    check("rsp_valid", {15'h0, rsp_valid}, 16'h0001);
    check("uv_action", rsp_rdata, 16'h0080);
    bus(1'b0, CMD_OC_LIMIT, 16'h0000);
    check("oc_reset", rsp_rdata, 16'hF0A0);
    for (i = 0; i < 12; i++) begin
      v = (i < 2) ? 600 + i * 350 : 600 + rnd(351);
      bus(1'b1, CMD_UV_LIMIT, 16'(v));
      check("uv_step", {12'h0, uv_step}, 16'((v - 600) / 25));
    end
    bus(1'b1, CMD_UV_LIMIT, 16'd599);
    check("uv_keep", {12'h0, uv_step}, 16'((v - 600) / 25));
    check("cml", {14'h0, s_cml, s_bcml}, 16'h0003);
    @(posedge core_clk);
    #1;
    check("alert", {14'h0, alert_oe, alert_out}, 16'h0002);
    bus(1'b1, CMD_UV_ACTION, 16'h00C5);
    bus(1'b0, CMD_UV_ACTION, 16'h0000);
    check("act_keep", rsp_rdata, 16'h0080);
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? 16 : (i == 1) ? 248 : (i == 2) ? 33 : 1 + rnd(248);
      phase_select <= 8'(i % 4);
      bus(1'b1, CMD_OC_LIMIT, {OC_EXP, 11'(v)});
      check("oc_step", {11'h0, oc_phase_step[i % 4]}, oc_exp(v));
      bus(1'b0, CMD_OC_LIMIT, 16'h0000);
      check("oc_rd", rsp_rdata, {OC_EXP, 11'(v)});
    end
    bus(1'b1, CMD_OC_LIMIT, {OC_EXP, 11'd249});
    check("oc_keep", {11'h0, oc_phase_step[3]}, oc_exp(v));
    phase_select <= PHASE_ALL;
    bus(1'b1, CMD_OC_LIMIT, {OC_EXP, 11'h200});
    check("oc_all", {11'h0, oc_phase_step[2]}, 16'h0010);
    @(posedge core_clk);
    #1;
    check("stack", {8'h0, stack_oc_step}, 16'h0040);
    bus(1'b0, CMD_OC_LIMIT, 16'h0000);
    check("oc_all_rd", rsp_rdata, {OC_EXP, 11'h200});
    seen = 1'b0;
    oc_trip <= 1'b1;
    repeat (8) @(posedge core_clk) seen |= oc_req;
    check("oc_req", {15'h0, seen}, 16'h0001);
    status_clear <= 1'b1;
    @(posedge core_clk);
    status_clear <= 1'b0;
    operation_on <= 1'b1;
    for (i = 0; i < 200 && !(startup_ok === 1'b1); i++) @(posedge core_clk);
    repeat (8) @(posedge core_clk);
    uv_force <= 1'b1;
    for (i = 0; i < 8 && regulator_enable !== 1'b0; i++) @(posedge core_clk);
    #1;
    check("reg_off", {15'h0, regulator_enable}, 16'h0000);
    check("uv_stat", {13'h0, s_other, s_word, s_uvf}, 16'h0007);
    repeat (2) @(posedge core_clk);
    #1;
    check("uv_alert", {15'h0, alert_oe}, 16'h0001);
    repeat (100) @(posedge core_clk);
    #1;
    check("latched", {15'h0, regulator_enable}, 16'h0000);
    operation_on <= 1'b0;
    uv_force <= 1'b0;
    bus(1'b1, CMD_UV_ACTION, 16'h0049);
    bus(1'b0, CMD_UV_ACTION, 16'h0000);
    check("act_delayed", rsp_rdata, 16'h0049);
    operation_on <= 1'b1;
    for (i = 0; i < 200 && !(startup_ok === 1'b1); i++) @(posedge core_clk);
    repeat (8) @(posedge core_clk);
    uv_force <= 1'b1;
    for (i = 0; i < 20 && regulator_enable !== 1'b0; i++) @(posedge core_clk);
    #1;
    check("dly_off", {15'h0, regulator_enable}, 16'h0000);
    for (i = 0; i < 60 && regulator_enable !== 1'b1; i++) @(posedge core_clk);
    #1;
    check("restart_wait_period_on", {15'h0, regulator_enable}, 16'h0001);
    report_and_stop();
  end
endmodule : uv_oc_fault_limit_response_regs_bench
`default_nettype wire
